/* bench/rss_exec_tb.sv */
// Self-checking testbench for the rotate, fill-ones and low-power execution block
`timescale 1ns/1ps
module rss_exec_tb;
    // ********************************
    // Signals and scoreboard
    // ********************************
    typedef struct packed {
        logic [1:0] kind; // 0 file write, 1 working write, 2 low power
        logic [11:0] addr;
        logic [7:0] data;
        logic fl; // Flag update expected
        logic n;
        logic z;
        logic [31:0] due; // Cycle the result must show in
    } note_t;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [15:0] instr_word = 16'h0000;
    logic instr_valid = 1'b0;
    logic ext_en = 1'b0;
    logic [3:0] bank_select_register = 4'h0;
    logic [7:0] fsr_base = 8'h00;
    logic [7:0] file_rdata;
    logic wdt_wake = 1'b0;
    logic [11:0] file_addr;
    logic file_rd, file_we, w_we, flag_we, neg_flag, zero_flag;
    logic [7:0] file_wdata, w_wdata;
    logic power_down_flag, timeout_flag, watchdog_clear, sleep_req, busy;
    logic [7:0] mem [0:4095]; // Register file the design sees
    logic [7:0] shadow [0:4095]; // Independent prediction of the register file
    logic [7:0] corner [4] = '{8'h5f, 8'h60, 8'h00, 8'hff}; // Ends of the low (00h-5Fh) and high (60h-FFh) access halves
    note_t notes[$];
    int n_fail = 0;
    int total_checks = 0;
    int cyc = 0;
    logic [15:0] w;
    rss_exec dut (.clk(clk), .sys_rst(sys_rst), .instr_word(instr_word), .instr_valid(instr_valid),
        .ext_en(ext_en), .bank_select_register(bank_select_register), .fsr_base(fsr_base),
        .file_rdata(file_rdata), .wdt_wake(wdt_wake), .file_addr(file_addr), .file_rd(file_rd),
        .file_we(file_we), .file_wdata(file_wdata), .w_we(w_we), .w_wdata(w_wdata), .flag_we(flag_we),
        .neg_flag(neg_flag), .zero_flag(zero_flag), .power_down_flag(power_down_flag),
        .timeout_flag(timeout_flag), .watchdog_clear(watchdog_clear), .sleep_req(sleep_req), .busy(busy));
    // Clock of 25 ns
    always #12.5 clk = ~clk;
    // Combinational register file read
    assign file_rdata = mem[file_addr];
    // Register file takes the design's writes
    always @(posedge clk) begin
        if (file_we === 1'b1) mem[file_addr] <= file_wdata;
    end
    // ********************************
    // Helpers
    // ********************************
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic final_report();
        $display("Checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : final_report
    // Bounded wait for the block to go idle
    task automatic wait_idle();
        int i;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            #1;
            if (busy === 1'b0) break;
        end
        if (i == 20) begin
            check("idle wait", 16'h1, 16'h0);
            final_report();
        end
    endtask : wait_idle
    // Sends one word; push notes the expected result, tail keeps valid up while busy
    task automatic issue(input logic [15:0] wd, input logic x, input logic [3:0] b, input logic [7:0] fb,
        input logic push, input logic tail);
        note_t nt;
        logic [7:0] f;
        logic [11:0] ad;
        logic [7:0] old;
        logic rd_exp;
        f = wd[7:0];
        rd_exp = ((wd & 16'hfc00) == 16'h4000);
        if (wd[8]) ad = {b, f};
        else if (x && f <= 8'h5f) ad = {4'h0, 8'(fb + f)};
        else if (f <= 8'h5f) ad = {4'h0, f};
        else ad = {4'hf, f};
        @(posedge clk);
        instr_word <= wd;
        instr_valid <= 1'b1;
        ext_en <= x;
        bank_select_register <= b;
        fsr_base <= fb;
        nt = '0;
        nt.addr = ad;
        nt.due = cyc + 4; // Take edge is the next one, result two edges later
        old = shadow[ad];
        if (push) begin
            if (wd == 16'h0003) nt.kind = 2'd2;
            else if ((wd & 16'hfe00) == 16'h6800) begin
                nt.data = 8'hff;
                shadow[ad] = 8'hff;
            end else begin
                nt.data = {old[0], old[7:1]};
                nt.fl = 1'b1;
                nt.n = old[0];
                nt.z = (nt.data == 8'h00);
                nt.kind = wd[9] ? 2'd0 : 2'd1;
                if (wd[9]) shadow[ad] = nt.data;
            end
            notes.push_back(nt);
        end
        @(posedge clk);
        // A fill word offered while busy must be ignored
        if (tail) instr_word <= 16'h6900 | {8'h00, f};
        else instr_valid <= 1'b0;
        #1;
        check("read strobe", 16'(file_rd), 16'(rd_exp));
        check("busy", 16'(busy), 16'(push));
        if (tail) begin
            @(posedge clk);
            instr_valid <= 1'b0;
        end
        wait_idle();
    endtask : issue
    // ********************************
    // Result monitor
    // ********************************
    always @(posedge clk) begin
        note_t nt;
        #1;
        cyc = cyc + 1;
        if (file_we === 1'b1 || w_we === 1'b1 || watchdog_clear === 1'b1) begin
            if (notes.size() == 0) check("unexpected result", 16'h1, 16'h0);
            else begin
                nt = notes.pop_front();
                check("latency", cyc[15:0], nt.due[15:0]);
                if (nt.kind == 2'd2) begin
                    check("power down", 16'(power_down_flag), 16'h0);
                    check("timeout", 16'(timeout_flag), 16'h1);
                    check("watchdog clear", 16'(watchdog_clear), 16'h1);
                    check("sleep request", 16'(sleep_req), 16'h1);
                end else begin
                    check("destination", 16'({file_we, w_we}), nt.kind == 2'd0 ? 16'h2 : 16'h1);
                    check("address", 16'(file_addr), 16'(nt.addr));
                    check("data", 16'(nt.kind == 2'd0 ? file_wdata : w_wdata), 16'(nt.data));
                    check("flag write", 16'(flag_we), 16'(nt.fl));
                    if (nt.fl) check("n z", 16'({neg_flag, zero_flag}), 16'({nt.n, nt.z}));
                end
            end
        end
    end
    // Hang guard
    initial begin
        #2000000;
        check("run time", 16'h1, 16'h0);
        final_report();
    end
    // ********************************
    // Main sequence
    // ********************************
    initial begin
        void'($urandom(32'hfc6e2924));
        for (int i = 0; i < 4096; i++) mem[i] = 8'($urandom);
        mem[12'h010] = 8'h01;
        mem[12'h011] = 8'h00;
        for (int i = 0; i < 4096; i++) shadow[i] = mem[i];
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        #1;
        check("reset flags", 16'({power_down_flag, timeout_flag, busy, sleep_req}), 16'hc);
        // Rotate corner values: bit 0 into bit 7, zero result
        issue(16'h4210, 1'b0, 4'h3, 8'h00, 1'b1, 1'b0);
        issue(16'h4010, 1'b0, 4'h3, 8'h00, 1'b1, 1'b0);
        issue(16'h4011, 1'b0, 4'h3, 8'h00, 1'b1, 1'b0);
        // Every d, a, extended and opcode mix over the boundary addresses, then random
        for (int i = 0; i < 40; i++) begin
            w[7:0] = (i < 16) ? corner[i % 4] : 8'($urandom);
            if (i < 16 ? i[3] : 1'($urandom)) w[15:8] = {7'b0110100, 1'(i < 16 ? i[1] : $urandom)};
            else w[15:8] = {6'b010000, 1'(i < 16 ? i[0] : $urandom), 1'(i < 16 ? i[1] : $urandom)};
            issue(w, 1'(i < 16 ? i[2] : $urandom), 4'($urandom), 8'($urandom), 1'b1, 1'b0);
        end
        // Word offered while busy is refused
        issue(16'h4230, 1'b1, 4'h5, 8'h20, 1'b1, 1'b1);
        // Near-miss and unknown opcodes do nothing
        issue(16'h1234, 1'b0, 4'h0, 8'h00, 1'b0, 1'b0);
        issue(16'h4400, 1'b0, 4'h0, 8'h00, 1'b0, 1'b0);
        issue(16'h6a00, 1'b0, 4'h0, 8'h00, 1'b0, 1'b0);
        issue(16'h0004, 1'b0, 4'h0, 8'h00, 1'b0, 1'b0);
        // Low power entry, watchdog wake, entry again
        issue(16'h0003, 1'b0, 4'h0, 8'h00, 1'b1, 1'b0);
        @(posedge clk);
        wdt_wake <= 1'b1;
        @(posedge clk);
        wdt_wake <= 1'b0;
        @(posedge clk);
        #1;
        check("wake flags", 16'({power_down_flag, timeout_flag, sleep_req}), 16'h0);
        issue(16'h0003, 1'b0, 4'h0, 8'h00, 1'b1, 1'b0);
        issue(16'h4210, 1'b0, 4'h0, 8'h00, 1'b1, 1'b0);
        // Reset in mid-run restores the status flags
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        #1;
        check("second reset", 16'({power_down_flag, timeout_flag, busy, sleep_req}), 16'hc);
        repeat (6) @(posedge clk);
        check("pending notes", 16'(notes.size()), 16'h0);
        final_report();
    end
endmodule : rss_exec_tb

/* logic/addr_bus_if.sv */
// Interface carrying the operand address between the execution block and the resolver
`timescale 1ns/1ps
interface addr_bus_if;
    logic [7:0] file_addr; // Raw 8-bit operand address
    logic access_sel; // Bank-access operand bit
    logic ext_en; // Extended instruction set on
    logic [3:0] bank_sel; // Bank select register value
    logic [7:0] fsr_base; // Index base for literal offset mode
    logic [11:0] full_addr; // Resolved data memory address
    modport requester (output file_addr, access_sel, ext_en, bank_sel, fsr_base, input full_addr);
    modport resolver (input file_addr, access_sel, ext_en, bank_sel, fsr_base, output full_addr);
endinterface : addr_bus_if

/* logic/addr_resolve.sv */
// Combinational data-memory address resolver for byte-oriented operands
`timescale 1ns/1ps
`include "rss_regs.svh"
module addr_resolve (
    addr_bus_if.resolver ab
);
    // ********************************
    // Address formation
    // ********************************
    // Indexed mode, access bank or banked address
    always_comb begin
        if (ab.access_sel) begin
            ab.full_addr = {ab.bank_sel, ab.file_addr}; // RULE5
        end else if (ab.ext_en && (ab.file_addr <= `IDX_LIMIT)) begin
            ab.full_addr = {4'h0, 8'(ab.fsr_base + ab.file_addr)}; // RULE6
        end else if (ab.file_addr < `ACCESS_HI_BASE) begin
            ab.full_addr = {4'h0, ab.file_addr}; // RULE4
        end else begin
            ab.full_addr = {`ACCESS_HI_BANK, ab.file_addr}; // RULE4
        end
    end
endmodule : addr_resolve

/* logic/rss_exec.sv */
// Execution logic for rotate-right, fill-ones and low-power entry
`timescale 1ns/1ps
`include "rss_regs.svh"
// Function
// RULE1: Rotate right, bit0 into bit7, N Z
// RULE2: Destination bit 0 writes working register
// RULE3: Destination bit 1 writes file register
// RULE4: Access bit 0 uses access bank
// RULE5: Access bit 1 uses bank register
// RULE6: Extended, access 0, addr<=95: indexed
// RULE7: Low-power opcode clears power-down flag
// RULE8: Low-power opcode sets timeout flag
// RULE9: Low-power opcode clears watchdog and postscaler
// RULE10: Watchdog wake clears timeout flag; a low-power entry in the same cycle wins and sets it
// RULE11: Fill-ones writes FFh, flags unchanged
// RULE12: One word, four phases per cycle
module rss_exec (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [15:0] instr_word,
    input wire logic instr_valid,
    input wire logic ext_en,
    input wire logic [3:0] bank_select_register,
    input wire logic [7:0] fsr_base,
    input wire logic [7:0] file_rdata,
    input wire logic wdt_wake,
    output logic [11:0] file_addr,
    output logic file_rd,
    output logic file_we,
    output logic [7:0] file_wdata,
    output logic w_we,
    output logic [7:0] w_wdata,
    output logic flag_we,
    output logic neg_flag,
    output logic zero_flag,
    output logic power_down_flag,
    output logic timeout_flag,
    output logic watchdog_clear,
    output logic sleep_req,
    output logic busy
);
    // ********************************
    // Decode helpers
    // ********************************
    // Classify an instruction word; used on capture, by the sequencer, the read strobe and busy
    function automatic rss_pkg::op_kind_t decode_op(input logic [15:0] iw);
        if ((iw & `ROT_OPC_MASK) == `ROT_OPC_VAL) begin
            decode_op = rss_pkg::OP_ROTATE; // RULE1
        end else if ((iw & `FILL_OPC_MASK) == `FILL_OPC_VAL) begin
            decode_op = rss_pkg::OP_FILL; // RULE11
        end else if (iw == `SLP_OPC_VAL) begin
            decode_op = rss_pkg::OP_SLEEP; // RULE7
        end else begin
            decode_op = rss_pkg::OP_NONE;
        end
    endfunction : decode_op

    // ********************************
    // State
    // ********************************
    rss_pkg::phase_t phase_reg; // Current phase
    rss_pkg::op_kind_t op_reg; // Latched operation
    logic [15:0] iw_reg; // Latched instruction word
    logic [7:0] operand_reg; // Operand read in the read phase
    logic [7:0] result_reg; // Processed data
    logic [11:0] addr_reg; // Resolved address held through the cycle
    logic [11:0] resolved; // Resolver output
    logic dest_file; // Destination bit of the latched word

    assign dest_file = iw_reg[`FLD_D_BIT];

    // Address resolver, shared by rotate and fill
    addr_bus_if ab ();
    // In decode the incoming word is resolved, so the read address stands before the read edge
    assign ab.file_addr = (phase_reg == rss_pkg::PH_DECODE) ? instr_word[7:0] : iw_reg[7:0];
    assign ab.access_sel = (phase_reg == rss_pkg::PH_DECODE) ? instr_word[`FLD_A_BIT] : iw_reg[`FLD_A_BIT];
    assign ab.ext_en = ext_en;
    assign ab.bank_sel = bank_select_register;
    assign ab.fsr_base = fsr_base;
    assign resolved = ab.full_addr;
    addr_resolve u_resolve (
        .ab(ab)
    );

    // ********************************
    // Phase sequencer
    // ********************************
    // Four phases per instruction; a new word is only taken in decode
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            phase_reg <= rss_pkg::PH_DECODE;
        end else begin
            case (phase_reg)
                rss_pkg::PH_DECODE: begin
                    if (instr_valid && decode_op(instr_word) != rss_pkg::OP_NONE) begin
                        phase_reg <= rss_pkg::PH_READ; // RULE12
                    end
                end
                rss_pkg::PH_READ: phase_reg <= rss_pkg::PH_PROCESS;
                rss_pkg::PH_PROCESS: phase_reg <= rss_pkg::PH_WRITE;
                rss_pkg::PH_WRITE: phase_reg <= rss_pkg::PH_DECODE;
                default: phase_reg <= rss_pkg::PH_DECODE;
            endcase
        end
    end

    // Instruction capture
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            iw_reg <= 16'h0000;
            op_reg <= rss_pkg::OP_NONE;
        end else if (phase_reg == rss_pkg::PH_DECODE && instr_valid) begin
            iw_reg <= instr_word;
            op_reg <= decode_op(instr_word);
        end
    end

    // ********************************
    // Data path
    // ********************************
    // Address held from the read phase for the address checks; the write uses file_addr
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            addr_reg <= 12'h000;
            operand_reg <= 8'h00;
        end else if (phase_reg == rss_pkg::PH_READ) begin
            addr_reg <= resolved; // RULE4
            operand_reg <= file_rdata;
        end
    end

    // Rotate or fill in the process phase
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            result_reg <= 8'h00;
        end else if (phase_reg == rss_pkg::PH_PROCESS) begin
            if (op_reg == rss_pkg::OP_ROTATE) begin
                result_reg <= {operand_reg[0], operand_reg[7:1]}; // RULE1
            end else begin
                result_reg <= `FILL_VALUE; // RULE11
            end
        end
    end

    // ********************************
    // Register file port
    // ********************************
    // Read strobe in the read phase; address reflects the resolved operand
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            file_addr <= 12'h000;
            file_rd <= 1'b0;
        end else begin
            file_rd <= (phase_reg == rss_pkg::PH_DECODE) && instr_valid
                && (decode_op(instr_word) == rss_pkg::OP_ROTATE);
            if (phase_reg == rss_pkg::PH_DECODE || phase_reg == rss_pkg::PH_READ) begin
                file_addr <= resolved; // RULE5
            end
        end
    end
    // Note: file_rdata is sampled one edge after file_rd, i.e. combinational read

    // Writes in the final phase, one pulse
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            file_we <= 1'b0;
            file_wdata <= 8'h00;
            w_we <= 1'b0;
            w_wdata <= 8'h00;
            flag_we <= 1'b0;
            neg_flag <= 1'b0;
            zero_flag <= 1'b0;
        end else begin
            file_we <= 1'b0;
            w_we <= 1'b0;
            flag_we <= 1'b0;
            if (phase_reg == rss_pkg::PH_PROCESS) begin
                if (op_reg == rss_pkg::OP_ROTATE) begin
                    // Destination select decides where the result lands
                    file_we <= dest_file; // RULE3
                    w_we <= !dest_file; // RULE2
                    file_wdata <= {operand_reg[0], operand_reg[7:1]};
                    w_wdata <= {operand_reg[0], operand_reg[7:1]};
                    flag_we <= 1'b1; // RULE1
                    neg_flag <= operand_reg[0];
                    zero_flag <= (operand_reg == 8'h00);
                end else if (op_reg == rss_pkg::OP_FILL) begin
                    file_we <= 1'b1; // RULE11
                    file_wdata <= `FILL_VALUE;
                end
            end
        end
    end

    // ********************************
    // Power status and watchdog
    // ********************************
    // Flags live here; the low-power entry pulses in the write phase
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            power_down_flag <= `PD_RESET;
            timeout_flag <= `TO_RESET;
            watchdog_clear <= 1'b0;
            sleep_req <= 1'b0;
        end else begin
            watchdog_clear <= 1'b0;
            if (wdt_wake) begin
                timeout_flag <= 1'b0; // RULE10
            end
            if (phase_reg == rss_pkg::PH_PROCESS && op_reg == rss_pkg::OP_SLEEP) begin
                power_down_flag <= 1'b0; // RULE7
                timeout_flag <= 1'b1; // RULE8
                watchdog_clear <= 1'b1; // RULE9
                sleep_req <= 1'b1;
            end else if (wdt_wake) begin
                sleep_req <= 1'b0;
            end
        end
    end

    // Busy while a cycle is in progress
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            busy <= 1'b0;
        end else begin
            busy <= (phase_reg == rss_pkg::PH_DECODE) ? (instr_valid && decode_op(instr_word) != rss_pkg::OP_NONE)
                : (phase_reg != rss_pkg::PH_WRITE);
        end
    end

    // ********************************
    // Checks
    // ********************************
    property p_rot_result; // RULE1
        @(posedge clk) disable iff (sys_rst)
        (phase_reg == rss_pkg::PH_PROCESS && op_reg == rss_pkg::OP_ROTATE)
            |=> (file_wdata == {$past(operand_reg[0]), $past(operand_reg[7:1])}) && flag_we;
    endproperty
    a_rot_result: assert property (p_rot_result) else $error("rotate result wrong"); // RULE1

    property p_dest_w; // RULE2
        @(posedge clk) disable iff (sys_rst)
        (phase_reg == rss_pkg::PH_PROCESS && op_reg == rss_pkg::OP_ROTATE && !dest_file) |=> w_we && !file_we;
    endproperty
    a_dest_w: assert property (p_dest_w) else $error("rotate to W misrouted"); // RULE2

    property p_dest_f; // RULE3
        @(posedge clk) disable iff (sys_rst)
        (phase_reg == rss_pkg::PH_PROCESS && op_reg == rss_pkg::OP_ROTATE && dest_file) |=> file_we && !w_we;
    endproperty
    a_dest_f: assert property (p_dest_f) else $error("rotate to f misrouted"); // RULE3

    property p_bank; // RULE5
        @(posedge clk) disable iff (sys_rst)
        (phase_reg == rss_pkg::PH_READ && iw_reg[`FLD_A_BIT]) |=> addr_reg[11:8] == $past(bank_select_register);
    endproperty
    a_bank: assert property (p_bank) else $error("bank not from bank register"); // RULE5

    property p_access; // RULE4
        @(posedge clk) disable iff (sys_rst)
        (phase_reg == rss_pkg::PH_READ && !iw_reg[`FLD_A_BIT] && !ext_en && iw_reg[7:0] < `ACCESS_HI_BASE)
            |=> addr_reg == {4'h0, $past(iw_reg[7:0])};
    endproperty
    a_access: assert property (p_access) else $error("access bank address wrong"); // RULE4

    property p_fill; // RULE11
        @(posedge clk) disable iff (sys_rst)
        (phase_reg == rss_pkg::PH_PROCESS && op_reg == rss_pkg::OP_FILL)
            |=> file_we && file_wdata == `FILL_VALUE && !flag_we;
    endproperty
    a_fill: assert property (p_fill) else $error("fill ones wrong"); // RULE11

    property p_sleep; // RULE8
        @(posedge clk) disable iff (sys_rst)
        (phase_reg == rss_pkg::PH_PROCESS && op_reg == rss_pkg::OP_SLEEP)
            |=> !power_down_flag && timeout_flag && watchdog_clear;
    endproperty
    a_sleep: assert property (p_sleep) else $error("low-power entry flags wrong"); // RULE8

    property p_wake; // RULE10
        @(posedge clk) disable iff (sys_rst)
        (wdt_wake && !(phase_reg == rss_pkg::PH_PROCESS && op_reg == rss_pkg::OP_SLEEP)) |=> !timeout_flag;
    endproperty
    a_wake: assert property (p_wake) else $error("timeout flag not cleared on wake"); // RULE10

    property p_cycle; // RULE12
        @(posedge clk) disable iff (sys_rst)
        (phase_reg == rss_pkg::PH_READ) |=> phase_reg == rss_pkg::PH_PROCESS ##1 phase_reg == rss_pkg::PH_WRITE
            ##1 phase_reg == rss_pkg::PH_DECODE;
    endproperty
    a_cycle: assert property (p_cycle) else $error("phase sequence broken"); // RULE12

    property p_index; // RULE6
        @(posedge clk) disable iff (sys_rst)
        (phase_reg == rss_pkg::PH_READ && !iw_reg[`FLD_A_BIT] && ext_en && iw_reg[7:0] <= `IDX_LIMIT)
            |=> addr_reg == {4'h0, 8'($past(fsr_base) + $past(iw_reg[7:0]))};
    endproperty
    a_index: assert property (p_index) else $error("indexed offset address wrong"); // RULE6

    // Read strobe and address must stand while the operand is sampled
    property p_read_strobe; // RULE12
        @(posedge clk) disable iff (sys_rst)
        (phase_reg == rss_pkg::PH_READ) |-> file_rd == (op_reg == rss_pkg::OP_ROTATE) && file_addr == resolved;
    endproperty
    a_read_strobe: assert property (p_read_strobe) else $error("operand read strobe or address wrong"); // RULE12

    // The held result and the written data come from two paths and must agree
    property p_result_agree; // RULE1
        @(posedge clk) disable iff (sys_rst)
        (file_we || w_we) |-> result_reg == (file_we ? file_wdata : w_wdata);
    endproperty
    a_result_agree: assert property (p_result_agree) else $error("written data differs from result"); // RULE1
endmodule : rss_exec

/* logic/rss_pkg.sv */
// Types for the rotate, fill-ones and low-power execution block
package rss_pkg;
    // Four instruction phases
    typedef enum logic [1:0] {PH_DECODE, PH_READ, PH_PROCESS, PH_WRITE} phase_t;
    // Decoded operation
    typedef enum logic [1:0] {OP_NONE, OP_ROTATE, OP_FILL, OP_SLEEP} op_kind_t;
endpackage : rss_pkg

/* logic/rss_regs.svh */
// Constants for the rotate, fill-ones and low-power execution block
`ifndef RSS_REGS_SVH
`define RSS_REGS_SVH
// ********************************
// Opcode patterns and masks
// ********************************
`define ROT_OPC_MASK 16'hfc00
`define ROT_OPC_VAL 16'h4000
`define FILL_OPC_MASK 16'hfe00
`define FILL_OPC_VAL 16'h6800
`define SLP_OPC_VAL 16'h0003
// ********************************
// Operand field positions
// ********************************
`define FLD_D_BIT 9
`define FLD_A_BIT 8
// ********************************
// Addressing and reset values
// ********************************
`define IDX_LIMIT 8'h5f
`define ACCESS_HI_BASE 8'h60
`define ACCESS_HI_BANK 4'hf
`define FILL_VALUE 8'hff
`define PD_RESET 1'b1
`define TO_RESET 1'b1
`endif
